// >>> src/fic_pkg.sv
// Shared constants and types for the framer interrupt and read-DMA control block
package fic_pkg;

    // Bus geometry
    localparam int FIC_DATA_W = 32;
    localparam int FIC_ADDR_W = 8;
    localparam logic [1:0] FIC_HTRANS_NONSEQ = 2'h2;
    localparam logic FIC_HRESP_OKAY = 1'b0;

    // Register byte offsets
    localparam logic [FIC_ADDR_W-1:0] FIC_ADDR_ICR = 8'h00;
    localparam logic [FIC_ADDR_W-1:0] FIC_ADDR_DCFG = 8'h04;
    localparam logic [FIC_ADDR_W-1:0] FIC_ADDR_STAT = 8'h08;
    localparam logic [FIC_ADDR_W-1:0] FIC_ADDR_IEN = 8'h0C;
    localparam logic [FIC_ADDR_W-1:0] FIC_ADDR_DSTAT = 8'h10;

    // Default sizes
    localparam int FIC_NUM_SRC = 8;
    localparam int FIC_NUM_CH = 4;
    localparam int FIC_CHAN_W = 3;
    localparam int FIC_CHAN_RSV_BIT = 2;

    // Reset values and writable-bit masks
    localparam logic [7:0] FIC_ICR_RST = 8'h00;
    localparam logic [7:0] FIC_DCFG_RST = 8'h00;
    localparam logic [7:0] FIC_ICR_WMASK = 8'h07;
    localparam logic [7:0] FIC_DCFG_WMASK = 8'hC7;

    typedef struct packed {
        logic [4:0] rsv;
        logic status_clear_mode;
        logic enable_auto_clear;
        logic block_interrupt_enable;
    } fic_icr_type;

    typedef struct packed {
        logic dma_reset;
        logic dma_enable;
        logic [2:0] rsv;
        logic [FIC_CHAN_W-1:0] read_dma_channel_select;
    } fic_dma_cfg_type;

    typedef enum logic [2:0] {
        FIC_DMA_IDLE = 3'b001,
        FIC_DMA_REQ = 3'b010,
        FIC_DMA_XFER = 3'b100
    } fic_dma_state_type;

    // A channel code is usable when its top bit is clear and the channel exists
    function automatic logic fic_chan_ok(input logic [FIC_CHAN_W-1:0] code, input int n);
        return !code[FIC_CHAN_RSV_BIT] && (int'(code) < n);
    endfunction

endpackage

// >>> src/fic_irq_bank.sv
// Sticky interrupt status bits and their per-bit enables
`timescale 1ns/1ps
`default_nettype none
module fic_irq_bank import fic_pkg::*; #(
    parameter int NUM_SRC = FIC_NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Status control
    input wire logic [NUM_SRC-1:0] event_set,
    input wire logic [NUM_SRC-1:0] status_clr,
    // Enable control
    input wire logic enable_wr,
    input wire logic [NUM_SRC-1:0] enable_wdata,
    input wire logic [NUM_SRC-1:0] enable_clr,
    // State
    output logic [NUM_SRC-1:0] status,
    output logic [NUM_SRC-1:0] enable
);

    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_bit
            wire next_status = event_set[i] | (status[i] & ~status_clr[i]);
            wire next_enable = enable_wr ? enable_wdata[i] : (enable[i] & ~enable_clr[i]);
            always_ff @(posedge clk) begin
                if (srst) begin
                    status[i] <= 1'b0;
                    enable[i] <= 1'b0;
                end else begin
                    // A new event outranks a clear in the same cycle
                    status[i] <= next_status;
                    enable[i] <= next_enable;
                end
            end
        end
    endgenerate

    AST_SET_WINS: assert property (@(posedge clk) disable iff (srst)
        event_set != '0 |=> (status & $past(event_set)) == $past(event_set))
        else $error("status event lost");

endmodule
`default_nettype wire

// >>> src/fic_dma_req.sv
// Read-DMA request sequencer for the selected channel
`timescale 1ns/1ps
`default_nettype none
module fic_dma_req import fic_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic enable,
    input wire logic abort,
    input wire logic chan_valid,
    input wire logic msg_ready,
    // Handshake, acknowledge already synchronised
    input wire logic ack_n,
    output logic req_n,
    output var fic_dma_state_type state
);

    wire go = enable && chan_valid && !abort;
    wire start = go && msg_ready && ack_n;

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= FIC_DMA_IDLE;
            req_n <= 1'b1;
        end else begin
            unique case (state)
                FIC_DMA_IDLE: begin
                    // Wait for the previous acknowledge to release first
                    if (start) begin
                        state <= FIC_DMA_REQ;
                        req_n <= 1'b0;
                    end
                end
                FIC_DMA_REQ: begin
                    if (!go) begin
                        state <= FIC_DMA_IDLE;
                        req_n <= 1'b1;
                    end else if (!ack_n) begin
                        state <= FIC_DMA_XFER;
                    end
                end
                FIC_DMA_XFER: begin
                    // Buffer drained or channel dropped ends the burst
                    if (!go || !msg_ready) begin
                        state <= FIC_DMA_IDLE;
                        req_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    AST_REQ_NEEDS_MSG: assert property (@(posedge clk) disable iff (srst)
        $fell(req_n) |-> $past(msg_ready && enable && chan_valid))
        else $error("request without complete message");

    AST_XFER_AFTER_ACK: assert property (@(posedge clk) disable iff (srst)
        $rose(state == FIC_DMA_XFER) |-> $past(!ack_n && !req_n))
        else $error("transfer started without acknowledge");

endmodule
`default_nettype wire

// >>> src/fic_top.sv
// Framer interrupt behaviour control and read-DMA channel select, AHB-Lite slave
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - channel code picks read-DMA channel; 1xx reserved
// - clear mode 0: status bits clear on read
// - clear mode 1: reads keep status; writes clear
// - auto-clear 0: enables survive status reads
// - auto-clear 1: status read clears matching enables
// - block enable 0 blocks every interrupt
// - three control bits read/write, reset zero
// - request only with complete message buffered
// - request low, then acknowledge low accepts data
module fic_top import fic_pkg::*; #(
    parameter int NUM_SRC = FIC_NUM_SRC,
    parameter int NUM_CH = FIC_NUM_CH
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [FIC_DATA_W-1:0] HWDATA,
    input wire logic HREADY,
    output logic [FIC_DATA_W-1:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt sources and request
    input wire logic [NUM_SRC-1:0] IRQ_SRC,
    output logic IRQ,
    // Read DMA
    input wire logic [NUM_CH-1:0] MSG_READY,
    input wire logic READ_DMA_ACKNOWLEDGE_N,
    output logic READ_DMA_REQUEST_N,
    output logic [NUM_CH-1:0] DMA_CHAN_SEL
);

    //////////////////////////////////////////////////////////////////////////
    // Bus front end

    logic [FIC_ADDR_W-1:0] a_addr;
    logic a_wr;
    logic a_rd;
    fic_icr_type interrupt_behaviour_control;
    fic_dma_cfg_type dcfg;
    logic [NUM_SRC-1:0] irq_status;
    logic [NUM_SRC-1:0] irq_enable;
    fic_dma_state_type dma_state;
    logic ack_meta;
    logic ack_sync;
    logic req_n;

    // Only word transfers are expected; size is not checked
    wire accept = HSEL && (HTRANS == FIC_HTRANS_NONSEQ) && HREADY;
    wire wr_fire = a_wr;
    wire rd_fire = a_rd && !HREADYOUT;
    wire next_hready = !(accept && !HWRITE);

    wire sel_icr = a_addr == FIC_ADDR_ICR;
    wire sel_dcfg = a_addr == FIC_ADDR_DCFG;
    wire sel_stat = a_addr == FIC_ADDR_STAT;
    wire sel_ien = a_addr == FIC_ADDR_IEN;
    wire sel_dstat = a_addr == FIC_ADDR_DSTAT;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            a_addr <= '0;
            a_wr <= 1'b0;
            a_rd <= 1'b0;
            HREADYOUT <= 1'b1;
            HRESP <= FIC_HRESP_OKAY;
        end else begin
            // Reads take one wait state so read data leave a flop
            if (accept) begin
                a_addr <= HADDR[FIC_ADDR_W-1:0];
            end
            a_wr <= accept && HWRITE;
            a_rd <= (accept && !HWRITE) || (a_rd && HREADYOUT);
            HREADYOUT <= next_hready;
            HRESP <= FIC_HRESP_OKAY;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control registers

    wire [7:0] wbyte = HWDATA[7:0];
    wire fic_icr_type next_icr = fic_icr_type'(wbyte & FIC_ICR_WMASK);
    wire fic_dma_cfg_type next_dcfg = fic_dma_cfg_type'(wbyte & FIC_DCFG_WMASK);
    // Only a zero-to-one write of the reset bit restarts the sequencer
    wire dma_abort = wr_fire && sel_dcfg && next_dcfg.dma_reset && !dcfg.dma_reset;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            interrupt_behaviour_control <= fic_icr_type'(FIC_ICR_RST);
            dcfg <= fic_dma_cfg_type'(FIC_DCFG_RST);
        end else begin
            if (wr_fire && sel_icr) begin
                interrupt_behaviour_control <= next_icr;
            end
            if (wr_fire && sel_dcfg) begin
                dcfg <= next_dcfg;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status and enables

    wire stat_read = rd_fire && sel_stat;
    wire stat_write = wr_fire && sel_stat;
    wire [NUM_SRC-1:0] wr_clr = stat_write ? HWDATA[NUM_SRC-1:0] : '0;
    wire [NUM_SRC-1:0] rd_clr =
        (stat_read && !interrupt_behaviour_control.status_clear_mode) ? irq_status : '0;
    wire [NUM_SRC-1:0] en_clr =
        (stat_read && interrupt_behaviour_control.enable_auto_clear) ? irq_status : '0;
    wire [NUM_SRC-1:0] active = irq_status & irq_enable;
    wire next_irq = interrupt_behaviour_control.block_interrupt_enable && (|active);

    fic_irq_bank #(
        .NUM_SRC(NUM_SRC)
    ) u_irq_bank (
        .clk(CORE_CLK),
        .srst(SRST),
        .event_set(IRQ_SRC),
        .status_clr(wr_clr | rd_clr),
        .enable_wr(wr_fire && sel_ien),
        .enable_wdata(HWDATA[NUM_SRC-1:0]),
        .enable_clr(en_clr),
        .status(irq_status),
        .enable(irq_enable)
    );

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= next_irq;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read DMA channel select and handshake

    wire [FIC_CHAN_W-1:0] chan_code = dcfg.read_dma_channel_select;
    wire chan_valid = fic_chan_ok(chan_code, NUM_CH);
    wire [NUM_CH-1:0] chan_onehot = {{(NUM_CH-1){1'b0}}, 1'b1} << chan_code;
    wire [NUM_CH-1:0] next_chan_sel = chan_valid ? chan_onehot : '0;
    wire msg_sel = |(MSG_READY & next_chan_sel);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            DMA_CHAN_SEL <= '0;
            ack_meta <= 1'b1;
            ack_sync <= 1'b1;
        end else begin
            DMA_CHAN_SEL <= next_chan_sel;
            ack_meta <= READ_DMA_ACKNOWLEDGE_N;
            ack_sync <= ack_meta;
        end
    end

    fic_dma_req u_dma_req (
        .clk(CORE_CLK),
        .srst(SRST),
        .enable(dcfg.dma_enable),
        .abort(dma_abort),
        .chan_valid(fic_chan_ok(chan_code, NUM_CH)),
        .msg_ready(msg_sel),
        .ack_n(ack_sync),
        .req_n(req_n),
        .state(dma_state)
    );

    assign READ_DMA_REQUEST_N = req_n;

    //////////////////////////////////////////////////////////////////////////
    // Read data

    wire [FIC_DATA_W-1:0] dstat_word = FIC_DATA_W'({dma_state, msg_sel, ack_sync, req_n});
    wire [FIC_DATA_W-1:0] rd_val =
        sel_icr ? FIC_DATA_W'(interrupt_behaviour_control) :
        sel_dcfg ? FIC_DATA_W'(dcfg) :
        sel_stat ? FIC_DATA_W'(irq_status) :
        sel_ien ? FIC_DATA_W'(irq_enable) :
        sel_dstat ? dstat_word : '0;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            HRDATA <= '0;
        end else if (rd_fire) begin
            HRDATA <= rd_val;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks

    AST_CHAN_RESERVED: assert property (@(posedge CORE_CLK) disable iff (SRST)
        dcfg.read_dma_channel_select[FIC_CHAN_RSV_BIT] |=> (DMA_CHAN_SEL == '0))
        else $error("reserved channel code connected a channel");

    AST_CLEAR_ON_READ: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (stat_read && !interrupt_behaviour_control.status_clear_mode) |=>
        ((irq_status & $past(irq_status) & ~$past(IRQ_SRC)) == '0))
        else $error("status survived a clearing read");

    AST_READ_KEEPS: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (stat_read && interrupt_behaviour_control.status_clear_mode) |=>
        ((irq_status & $past(irq_status)) == $past(irq_status)))
        else $error("status lost on read in write-clear mode");

    AST_ENABLE_KEEP: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (stat_read && !interrupt_behaviour_control.enable_auto_clear) |=> irq_enable == $past(irq_enable))
        else $error("enable changed on status read");

    AST_ENABLE_AUTOCLR: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (stat_read && interrupt_behaviour_control.enable_auto_clear) |=> ((irq_enable & $past(irq_status)) == '0))
        else $error("enable kept after status read");

    AST_BLOCK_OFF: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !interrupt_behaviour_control.block_interrupt_enable [*2] |-> !IRQ)
        else $error("interrupt with block disabled");

    AST_CTRL_RESET: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $past(SRST) |-> (interrupt_behaviour_control == fic_icr_type'(FIC_ICR_RST)))
        else $error("control bits not zero after reset");

    AST_IRQ_LEVEL: assert property (@(posedge CORE_CLK) disable iff (SRST)
        ##1 IRQ == $past(interrupt_behaviour_control.block_interrupt_enable && |(irq_status & irq_enable)))
        else $error("interrupt level mismatch");

    AST_READ_WAIT: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (accept && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");

    //////////////////////////////////////////////////////////////////////////
    // Status, enable, control, channel select, interrupt, handshake and bus checks

    AST_WRITE_CLEAR: assert property (@(posedge CORE_CLK) disable iff (SRST)
        stat_write |=> ((irq_status & $past(HWDATA[NUM_SRC-1:0]) & ~$past(IRQ_SRC)) == '0))
        else $error("status survived a write of one");

    AST_ENABLE_WRITE: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (wr_fire && sel_ien) |=> (irq_enable == $past(HWDATA[NUM_SRC-1:0])))
        else $error("enable write not applied");

    AST_CTRL_WRITE: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (wr_fire && sel_icr) |=> (interrupt_behaviour_control == $past(next_icr)))
        else $error("control write not applied");

    AST_CTRL_READ: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (rd_fire && sel_icr) |=> (HRDATA == FIC_DATA_W'($past(interrupt_behaviour_control))))
        else $error("control read data wrong");

    AST_DCFG_WRITE: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (wr_fire && sel_dcfg) |=> (dcfg == $past(next_dcfg)))
        else $error("channel select write not applied");

    AST_CHAN_ZERO: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (chan_code == '0) |=> (DMA_CHAN_SEL == {{(NUM_CH-1){1'b0}}, 1'b1}))
        else $error("code zero did not pick channel zero");

    AST_CHAN_ONEHOT: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $onehot0(DMA_CHAN_SEL))
        else $error("more than one channel connected");

    AST_IRQ_NONE: assert property (@(posedge CORE_CLK) disable iff (SRST)
        ((irq_status & irq_enable) == '0) |=> !IRQ)
        else $error("interrupt without an enabled source");

    AST_IRQ_SET: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (interrupt_behaviour_control.block_interrupt_enable && ((irq_status & irq_enable) != '0)) |=> IRQ)
        else $error("enabled source raised no interrupt");

    // Software may poll without a message; the request must stay quiet then
    AST_NO_REQ_NO_MSG: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (READ_DMA_REQUEST_N && !msg_sel) |=> READ_DMA_REQUEST_N)
        else $error("request raised without a message");

    AST_NO_REQ_DISABLED: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (READ_DMA_REQUEST_N && !dcfg.dma_enable) |=> READ_DMA_REQUEST_N)
        else $error("request raised while disabled");

    // A new request into a still-low acknowledge would look like an instant grant
    AST_NO_REQ_WHILE_ACK: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (READ_DMA_REQUEST_N && !ack_sync) |=> READ_DMA_REQUEST_N)
        else $error("request raised before acknowledge released");

    AST_REQ_HOLD: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!READ_DMA_REQUEST_N && dcfg.dma_enable && chan_valid && !dma_abort && msg_sel)
        |=> !READ_DMA_REQUEST_N)
        else $error("request dropped while still wanted");

    AST_XFER_REQ_LOW: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (dma_state == FIC_DMA_XFER) |-> !READ_DMA_REQUEST_N)
        else $error("transfer without request");

    AST_ABORT_DROPS: assert property (@(posedge CORE_CLK) disable iff (SRST)
        dma_abort |=> READ_DMA_REQUEST_N)
        else $error("request kept through sequencer reset");

    AST_WRITE_NO_WAIT: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (accept && HWRITE) |=> HREADYOUT)
        else $error("write inserted a wait state");

    AST_HRESP_OKAY: assert property (@(posedge CORE_CLK) disable iff (SRST)
        HRESP == FIC_HRESP_OKAY)
        else $error("response not okay");

endmodule
`default_nettype wire

// >>> dv/fic_dma_model.sv
// External DMA controller model answering the read-DMA request
`timescale 1ns/1ps
`default_nettype none
module fic_dma_model (
    // Clock
    input wire logic clk,
    // Handshake
    input wire logic req_n,
    input wire logic [3:0] delay,
    output logic ack_n
);
    logic [3:0] cnt = 4'h0;
    logic ack_low = 1'b0;

    assign ack_n = !ack_low;

    // Acknowledge only once the request has stood low for the chosen delay
    always @(posedge clk) begin
        if (req_n) begin
            ack_low <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt >= delay) begin
            ack_low <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking testbench for the interrupt control and read-DMA select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fic_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] irq_src = 8'h00;
    logic [3:0] msg_ready = 4'h0;
    logic [3:0] ack_dly = 4'h1;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq, req_n, ack_n;
    wire logic [3:0] chan_sel;
    int err_count = 0;
    int check_count = 0;

    always #20 core_clk = ~core_clk;

    fic_top dut_u (.CORE_CLK(core_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .IRQ_SRC(irq_src), .IRQ(irq), .MSG_READY(msg_ready),
        .READ_DMA_ACKNOWLEDGE_N(ack_n), .READ_DMA_REQUEST_N(req_n),
        .DMA_CHAN_SEL(chan_sel));

    fic_dma_model host_u (.clk(core_clk), .req_n(req_n), .delay(ack_dly), .ack_n(ack_n));

    ////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Slave wait states are never assumed; the watchdog ends a hang
    task automatic wait_rdy;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= FIC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic pulse(input logic [7:0] s);
        @(posedge core_clk);
        irq_src <= s;
        @(posedge core_clk);
        irq_src <= 8'h00;
    endtask

    task automatic irq_is(input logic v);
        tick(2);
        chk({31'h0, irq}, {31'h0, v});
    endtask

    task automatic wait_req(input logic v);
        int n;
        n = 0;
        while (req_n !== v && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, req_n}, {31'h0, v});
    endtask

    ////////////////////////////////////////
    task automatic t_regs;
        rd(FIC_ADDR_ICR, 32'h0);
        rd(FIC_ADDR_STAT, 32'h0);
        wr(FIC_ADDR_ICR, 32'hFF);
        rd(FIC_ADDR_ICR, 32'h7);
        wr(FIC_ADDR_ICR, 32'h0);
        rd(FIC_ADDR_ICR, 32'h0);
        wr(8'h20, 32'hFF);
        rd(8'h20, 32'h0);
    endtask

    task automatic t_gate;
        wr(FIC_ADDR_IEN, 32'h05);
        wr(FIC_ADDR_ICR, 32'h1);
        pulse(8'h04);
        irq_is(1'b1);
        wr(FIC_ADDR_ICR, 32'h0);
        irq_is(1'b0);
        wr(FIC_ADDR_ICR, 32'h1);
        irq_is(1'b1);
        wr(FIC_ADDR_IEN, 32'h02);
        irq_is(1'b0);
        wr(FIC_ADDR_IEN, 32'h05);
        irq_is(1'b1);
    endtask

    task automatic t_clr;
        rd(FIC_ADDR_STAT, 32'h04);
        rd(FIC_ADDR_STAT, 32'h00);
        irq_is(1'b0);
        wr(FIC_ADDR_ICR, 32'h4);
        pulse(8'h03);
        rd(FIC_ADDR_STAT, 32'h03);
        rd(FIC_ADDR_STAT, 32'h03);
        wr(FIC_ADDR_STAT, 32'h01);
        rd(FIC_ADDR_STAT, 32'h02);
        wr(FIC_ADDR_STAT, 32'h02);
        rd(FIC_ADDR_STAT, 32'h00);
    endtask

    task automatic t_auto;
        wr(FIC_ADDR_ICR, 32'h2);
        wr(FIC_ADDR_IEN, 32'hFF);
        pulse(8'h10);
        rd(FIC_ADDR_STAT, 32'h10);
        rd(FIC_ADDR_IEN, 32'hEF);
        wr(FIC_ADDR_ICR, 32'h0);
        wr(FIC_ADDR_IEN, 32'hFF);
        pulse(8'h10);
        rd(FIC_ADDR_STAT, 32'h10);
        rd(FIC_ADDR_IEN, 32'hFF);
    endtask

    // Every code, the reserved ones included, with the request path disabled; then reserved code 4 with it enabled
    task automatic t_chan;
        for (int c = 0; c < 8; c++) begin
            wr(FIC_ADDR_DCFG, c);
            tick(2);
            chk({28'h0, chan_sel}, (c < FIC_NUM_CH) ? (32'h1 << c) : 32'h0);
        end
        wr(FIC_ADDR_DCFG, 32'h44);
        msg_ready <= 4'hF;
        tick(8);
        chk({31'h0, req_n}, 32'h1);
        msg_ready <= 4'h0;
    endtask

    task automatic t_dma(input logic [3:0] dly);
        ack_dly <= dly;
        wr(FIC_ADDR_DCFG, 32'h41);
        tick(8);
        chk({31'h0, req_n}, 32'h1);
        msg_ready <= 4'h1;
        tick(8);
        chk({31'h0, req_n}, 32'h1);
        msg_ready <= 4'h2;
        wait_req(1'b0);
        tick(dly + 6);
        rd(FIC_ADDR_DSTAT, 32'h24);
        msg_ready <= 4'h0;
        wait_req(1'b1);
        tick(6);
        rd(FIC_ADDR_DSTAT, 32'h0B);
        // Sequencer reset in mid-transfer must drop the request; removing the message keeps it high
        msg_ready <= 4'h2;
        wait_req(1'b0);
        tick(dly + 6);
        wr(FIC_ADDR_DCFG, 32'hC1);
        wait_req(1'b1);
        msg_ready <= 4'h0;
        tick(6);
        chk({31'h0, req_n}, 32'h1);
    endtask

    ////////////////////////////////////////
    initial begin
        tick(8);
        srst <= 1'b0;
        t_regs();
        t_gate();
        t_clr();
        t_auto();
        t_chan();
        t_dma(4'h1);
        t_dma(4'h6);
        print_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        tick(5000);
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
